// [inc/rdc_map.vh]
// Register map, field positions, reset values and the maximum count of the reload down counter core.
`ifndef RDC_MAP_VH
`define RDC_MAP_VH

// ==========================================================
// Register offsets (byte addresses)
`define RDC_OFS_CNT0 12'h000
`define RDC_OFS_CNT1 12'h004
`define RDC_OFS_CTRL0 12'h008
`define RDC_OFS_CTRL1 12'h00C
`define RDC_OFS_IRQ_STAT 12'h010
`define RDC_OFS_IRQ_EN 12'h014
`define RDC_OFS_IRQ_CLR 12'h018

// ==========================================================
// Control register fields
`define RDC_CTRL_TRG 0
`define RDC_CTRL_EN 1
`define RDC_CTRL_RELD 2
`define RDC_CTRL_PSC_LO 8
`define RDC_CTRL_PSC_HI 15

// ==========================================================
// Reset values and the maximum count
`define RDC_RST_CNT 16'h0000
`define RDC_RST_RLD 16'h0000
`define RDC_RST_PSC 8'h00
`define RDC_CNT_MAX 16'hFFFF

`endif

// [verilog/rdc_core.v]
// Two-instance 16-bit reload down counter core with APB registers and interrupt.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "rdc_map.vh"

module rdc_core (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // External start triggers, asynchronous pins
  input wire [1:0] ext_trig,
  // Interrupt and transfer service requests
  output wire irq,
  output wire [1:0] xfer_req
);

  // ==========================================================
  // Bus decode
  wire wr_en;
  wire rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `RDC_OFS_CNT0) || (a == `RDC_OFS_CNT1) ||
                  (a == `RDC_OFS_CTRL0) || (a == `RDC_OFS_CTRL1) ||
                  (a == `RDC_OFS_IRQ_STAT) || (a == `RDC_OFS_IRQ_EN) ||
                  (a == `RDC_OFS_IRQ_CLR);
    end
  endfunction

  // Writes to the counter words that leave out either of the two low byte strobes are refused with an error.
  function word_ok;
    input [11:0] a;
    input [3:0] s;
    begin
      if ((a == `RDC_OFS_CNT0) || (a == `RDC_OFS_CNT1)) begin
        word_ok = (s[1:0] == 2'b11);
      end else begin
        word_ok = 1'b1;
      end
    end
  endfunction

  // Both refusals are reported in the access phase only, where the master samples them.
  wire bad_addr;
  wire bad_width;
  assign bad_addr = ~is_mapped(paddr);
  assign bad_width = pwrite & ~word_ok(paddr, pstrb);
  assign pslverr = psel & penable & (bad_addr | bad_width);

  // ==========================================================
  // Trigger pin synchronisers
  wire [1:0] trig_rise;

  genvar si;
  generate
    for (si = 0; si < 2; si = si + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;

      // Only the second stage feeds logic; the third only remembers it for edge detection.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= ext_trig[si];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end

      // The pins idle low and the stages reset low, so no false edge follows reset.
      assign trig_rise[si] = s2_r & ~s3_r;
    end
  endgenerate

  // ==========================================================
  // Interrupt registers
  reg [1:0] uf_flag_r;
  reg [1:0] uf_flag_nxt;
  reg [1:0] irq_en_r;
  reg [1:0] irq_en_nxt;
  wire [1:0] uf_pulse;
  wire clr_wr;
  wire en_wr;
  assign clr_wr = wr_en & (paddr == `RDC_OFS_IRQ_CLR);
  assign en_wr = wr_en & (paddr == `RDC_OFS_IRQ_EN);

  always @* begin
    irq_en_nxt = irq_en_r;
    if (en_wr) begin
      irq_en_nxt = pwdata[1:0];
    end
    uf_flag_nxt = uf_flag_r;
    if (clr_wr) begin
      uf_flag_nxt = uf_flag_r & ~pwdata[1:0];
    end
    // Set wins over a clear in the same cycle, so no underflow is ever lost.
    uf_flag_nxt = uf_flag_nxt | uf_pulse;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uf_flag_r <= 2'b00;
      irq_en_r <= 2'b00;
    end else begin
      uf_flag_r <= uf_flag_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  assign irq = |(uf_flag_r & irq_en_r);

  // ==========================================================
  // Counter instances
  // Each instance walks from stopped, to waiting for a trigger, to running.
  localparam ST_STOP = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;

  wire [15:0] cnt_val [0:1];
  wire [31:0] ctrl_val [0:1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
      reg [15:0] cnt_r;
      reg [15:0] cnt_nxt;
      reg [15:0] rld_r;
      reg [15:0] rld_nxt;
      reg en_r;
      reg en_nxt;
      reg reld_r;
      reg reld_nxt;
      reg [2:0] state_r;
      reg [2:0] state_nxt;
      reg [7:0] psc_r;
      reg [7:0] psc_nxt;
      reg [7:0] div_r;
      reg [7:0] div_nxt;
      reg uf_r;
      reg uf_nxt;
      wire ofs_cnt;
      wire ofs_ctl;
      wire ctl_wr;
      wire sw_trg;
      wire hw_trg;
      wire trig;
      wire tick;

      assign ofs_cnt = (paddr == (gi ? `RDC_OFS_CNT1 : `RDC_OFS_CNT0));
      assign ofs_ctl = (paddr == (gi ? `RDC_OFS_CTRL1 : `RDC_OFS_CTRL0));
      assign ctl_wr = wr_en & ofs_ctl;
      assign sw_trg = ctl_wr & pwdata[`RDC_CTRL_TRG];
      assign hw_trg = trig_rise[gi];
      // A trigger written together with enable starts at once.
      assign trig = (sw_trg ? pwdata[`RDC_CTRL_EN] : en_r) & (sw_trg | hw_trg);
      // Count tick from a divider: one tick every psc_r+1 cycles.
      assign tick = (div_r == 8'h00);

      always @* begin
        cnt_nxt = cnt_r;
        rld_nxt = rld_r;
        en_nxt = en_r;
        reld_nxt = reld_r;
        state_nxt = state_r;
        psc_nxt = psc_r;
        div_nxt = div_r;
        uf_nxt = 1'b0;

        if (wr_en && ofs_cnt && word_ok(paddr, pstrb)) begin
          rld_nxt = pwdata[15:0];
        end
        if (ctl_wr) begin
          en_nxt = pwdata[`RDC_CTRL_EN];
          reld_nxt = pwdata[`RDC_CTRL_RELD];
          psc_nxt = pwdata[`RDC_CTRL_PSC_HI:`RDC_CTRL_PSC_LO];
        end

        case (state_r)
          ST_STOP: begin
            if (ctl_wr && pwdata[`RDC_CTRL_EN]) begin
              state_nxt = ST_WAIT;
            end
          end
          ST_WAIT: begin
            state_nxt = ST_WAIT;
          end
          ST_RUN: begin
            if (tick) begin
              div_nxt = psc_r;
              cnt_nxt = cnt_r - 16'h0001;
              if (cnt_r == 16'h0000) begin
                uf_nxt = 1'b1;
                if (reld_r) begin
                  cnt_nxt = rld_r;
                end else begin
                  cnt_nxt = `RDC_CNT_MAX;
                  state_nxt = ST_WAIT;
                end
              end
            end else begin
              div_nxt = div_r - 8'h01;
            end
          end
          default: begin
            state_nxt = ST_STOP;
          end
        endcase

        // A trigger while running restarts from the reload value.
        if (trig) begin
          cnt_nxt = rld_r;
          div_nxt = psc_r;
          uf_nxt = 1'b0;
          state_nxt = ST_RUN;
        end

        // Disabling drops back to the stopped state; the count is kept.
        if (ctl_wr && !pwdata[`RDC_CTRL_EN]) begin
          state_nxt = ST_STOP;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= `RDC_RST_CNT;
          rld_r <= `RDC_RST_RLD;
          en_r <= 1'b0;
          reld_r <= 1'b0;
          state_r <= ST_STOP;
          psc_r <= `RDC_RST_PSC;
          div_r <= `RDC_RST_PSC;
          uf_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          rld_r <= rld_nxt;
          en_r <= en_nxt;
          reld_r <= reld_nxt;
          state_r <= state_nxt;
          psc_r <= psc_nxt;
          div_r <= div_nxt;
          uf_r <= uf_nxt;
        end
      end

      assign uf_pulse[gi] = uf_r;
      assign xfer_req[gi] = uf_r;
      assign cnt_val[gi] = cnt_r;
      // The running bit is the one-hot run state itself.
      assign ctrl_val[gi] = {16'h0000, psc_r, 4'h0, state_r[2], reld_r, en_r, 1'b0};
    end
  endgenerate

  // ==========================================================
  // Read data, captured in the setup cycle
  // Capturing at setup keeps prdata steady through the access phase while the count moves.
  reg [31:0] prdata_nxt;

  always @* begin
    prdata_nxt = prdata;
    if (rd_en) begin
      case (paddr)
        `RDC_OFS_CNT0: prdata_nxt = {16'h0000, cnt_val[0]};
        `RDC_OFS_CNT1: prdata_nxt = {16'h0000, cnt_val[1]};
        `RDC_OFS_CTRL0: prdata_nxt = ctrl_val[0];
        `RDC_OFS_CTRL1: prdata_nxt = ctrl_val[1];
        `RDC_OFS_IRQ_STAT: prdata_nxt = {30'h0000_0000, uf_flag_r};
        `RDC_OFS_IRQ_EN: prdata_nxt = {30'h0000_0000, irq_en_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_nxt;
    end
  end

endmodule

// [testbench/rdc_core_chk.sv]
// Port-level assertions for the reload down counter core.
`timescale 1ns/100ps
module rdc_chk (
  // APB
  input wire pclk, input wire presetn, input wire psel, input wire penable,
  input wire pwrite, input wire [11:0] paddr, input wire [3:0] pstrb,
  input wire [31:0] prdata, input wire pslverr,
  // Requests
  input wire irq, input wire [1:0] xfer_req
);
  wire acc = psel && penable;
  wire cnt = acc && paddr < 12'h008;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cnt_width: assert property (cnt && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("count read too wide");
  a_word_only: assert property (cnt && pwrite && pstrb[1:0] != 2'b11 |-> pslverr)
    else $error("narrow count write accepted");
  a_word_ok: assert property (cnt && pstrb == 4'hF |-> !pslverr)
    else $error("word access refused");
  a_uf_pulse0: assert property ($rose(xfer_req[0]) |=> !xfer_req[0])
    else $error("transfer request too long");
  a_uf_pulse1: assert property ($rose(xfer_req[1]) |=> !xfer_req[1])
    else $error("transfer request too long");
  a_stat_width: assert property (acc && !pwrite && paddr == 12'h010 |-> prdata[31:2] == 0)
    else $error("status read too wide");
  a_irq_cause: assert property ($rose(irq) |->
    $past(xfer_req) != 2'b00 || $past(acc && pwrite && paddr == 12'h014))
    else $error("interrupt without cause");
  a_irq_drop: assert property ($fell(irq) |-> $past(acc && pwrite && paddr >= 12'h014))
    else $error("interrupt dropped without write");
endmodule
bind rdc_core rdc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .irq(irq), .xfer_req(xfer_req));

// [testbench/tb_rdc_core.sv]
// Self-checking bench for the reload down counter core.
`timescale 1ns/100ps
module tb_rdc_core;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [3:0] pstrb = 4'hF;
  reg [1:0] ext_trig = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [1:0] xfer_req;
  reg [31:0] rd, keep;
  reg err;
  integer err_total = 0, comparisons = 0, cyc = 0, t, n;
  always #5 pclk = ~pclk;
  rdc_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trig(ext_trig), .irq(irq), .xfer_req(xfer_req));
  // ==========================================================
  // Shared tasks
  task final_report;
    begin
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // The master idles one cycle first, so release and the next setup never share an edge.
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    begin
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      t = 0;
      while (pready !== 1'b1 && t < 50) begin
        @(posedge pclk);
        t = t + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask
  task uf(input i);
    begin
      n = 0;
      @(posedge pclk);
      while (xfer_req[i] !== 1'b1 && n < 300) begin
        @(posedge pclk);
        n = n + 1;
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  task s_oneshot;
    begin
      apb(1, 12'h000, 3, 4'hF); apb(1, 12'h014, 1, 4'hF); apb(1, 12'h008, 3, 4'hF);
      uf(0); #1 chk(irq, 1);
      apb(0, 12'h000, 0, 4'hF); chk(rd, 32'h0000_FFFF);
      apb(0, 12'h010, 0, 4'hF); chk(rd, 1);
      apb(1, 12'h008, 1, 4'hF); repeat (9) @(posedge pclk);
      apb(0, 12'h000, 0, 4'hF); chk(rd, 32'h0000_FFFF);
      apb(1, 12'h018, 1, 4'hF); #1 chk(irq, 0);
    end
  endtask
  task s_reload;
    begin
      apb(1, 12'h004, 5, 4'hF); apb(1, 12'h00C, 7, 4'hF);
      apb(0, 12'h004, 0, 4'hF); chk(rd <= 5, 1);
      uf(1); uf(1); chk(n, 5);
      apb(0, 12'h010, 0, 4'hF); chk(rd, 2);
      chk(irq, 0);
      apb(1, 12'h00C, 4, 4'hF); apb(0, 12'h004, 0, 4'hF); keep = rd;
      apb(1, 12'h004, 32'h0000_1234, 4'hF); repeat (8) @(posedge pclk);
      apb(0, 12'h004, 0, 4'hF); chk(rd, keep);
    end
  endtask
  task s_ext;
    begin
      apb(1, 12'h014, 1, 4'hF);
      apb(1, 12'h000, 2, 4'hF); apb(1, 12'h008, 2, 4'hF);
      @(posedge pclk) ext_trig <= 2'b01;
      uf(0); chk(n < 20, 1);
      #1 chk(irq, 1);
      apb(1, 12'h018, 1, 4'hF); ext_trig <= 2'b00;
    end
  endtask
  task s_err;
    begin
      apb(1, 12'h020, 1, 4'hF); chk(err, 1);
      apb(0, 12'h020, 0, 4'hF); chk(rd, 0);
      apb(1, 12'h000, 9, 4'h1); chk(err, 1);
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    chk(irq, 0);
    s_err;
    s_oneshot;
    s_reload;
    s_ext;
    final_report;
  end
endmodule
